// [include/rbo_params.svh]
/*
 * offsets, field positions, reset values and fifo figures of the
 * receive byte ordering and phase compensation block.
 * assumes a byte-addressed register port with 32-bit words.
 */
`ifndef RBO_PARAMS_SVH
`define RBO_PARAMS_SVH

// ***********************************
// register offsets
// ***********************************
`define RBO_ADDR_CTRL      8'h00
`define RBO_ADDR_PATTERN   8'h04
`define RBO_ADDR_STATUS    8'h08

// ***********************************
// control fields
// ***********************************
`define RBO_CTRL_DESER_EN  0
`define RBO_CTRL_DWIDTH    1
`define RBO_CTRL_USER_ORD  2
`define RBO_CTRL_ORD_EN    3
`define RBO_CTRL_HI_LAT    4
`define RBO_CTRL_CLKCFG_LO 5
`define RBO_CTRL_CLKCFG_HI 6
`define RBO_CTRL_CORE_INST 7
`define RBO_CTRL_RESET     32'h0000_0009

// ***********************************
// pattern fields: order pattern low half, pad high half
// ***********************************
`define RBO_PAT_LO         0
`define RBO_PAT_HI         15
`define RBO_PAD_LO         16
`define RBO_PAD_HI         31
`define RBO_PATTERN_RESET  32'h0000_0000

// ***********************************
// fifo depths and read start levels
// ***********************************
`define RBO_FIFO_DEPTH_LO  4'h4
`define RBO_FIFO_DEPTH_HI  4'h8
`define RBO_FIFO_START_LO  4'h2
`define RBO_FIFO_START_HI  4'h4

`endif

// [include/rbo_pkg.sv]
/*
 * types of the receive byte ordering and phase compensation block.
 * assumes nothing of its surroundings.
 */
package rbo_pkg;

   typedef enum logic [1:0] {
      rbo_clk_nb_rm,
      rbo_clk_nb_norm,
      rbo_clk_bond4,
      rbo_clk_bond8
   } rbo_clk_cfg_type;

   typedef enum logic {
      rbo_ord_idle,
      rbo_ord_search
   } rbo_ord_state_type;

endpackage

// [rtl/rbo_fifo.sv]
/*
 * phase compensation fifo, eight entries, four or eight in use.
 * assumes write enable and read tick come from logic on mclk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rbo_params.svh"

module rbo_fifo #(
   parameter int W = 33
) (
   input  wire logic         mclk,
   input  wire logic         rstn,
   input  wire logic         hi_lat,
   input  wire logic         wr_en,
   input  wire logic [W-1:0] wr_data,
   input  wire logic         rd_tick,
   output logic      [W-1:0] rd_data_ff,
   output logic              rd_valid_ff,
   output logic              err_ff
);

   logic [W-1:0] mem [0:7];
   logic [2:0]   wp_ff;
   logic [2:0]   rp_ff;
   logic [3:0]   cnt_ff;
   logic         primed_ff;
   wire  [3:0]   lim   = hi_lat ? `RBO_FIFO_DEPTH_HI : `RBO_FIFO_DEPTH_LO;
   wire  [3:0]   start = hi_lat ? `RBO_FIFO_START_HI : `RBO_FIFO_START_LO;
   wire          full  = (cnt_ff >= lim);
   wire          empty = (cnt_ff == 4'h0);
   wire          do_wr = wr_en && !full;
   wire          do_rd = rd_tick && primed_ff && !empty;
   wire  [2:0]   wp_nxt = hi_lat ? wp_ff + 3'h1 : {1'b0, wp_ff[1:0] + 2'h1};
   wire  [2:0]   rp_nxt = hi_lat ? rp_ff + 3'h1 : {1'b0, rp_ff[1:0] + 2'h1};
   wire  [3:0]   nxt_cnt = cnt_ff + {3'h0, do_wr} - {3'h0, do_rd};

   // ***********************************
   // storage and pointers
   // ***********************************
   always_ff @(posedge mclk) begin
      if (do_wr) begin
         mem[wp_ff] <= wr_data;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         wp_ff       <= 3'h0;
         rp_ff       <= 3'h0;
         cnt_ff      <= 4'h0;
         primed_ff   <= 1'b0;
         rd_data_ff  <= '0;
         rd_valid_ff <= 1'b0;
         err_ff      <= 1'b0;
      end else begin
         if (do_wr) begin
            wp_ff <= wp_nxt;
         end
         if (do_rd) begin
            rp_ff      <= rp_nxt;
            rd_data_ff <= mem[rp_ff];
         end
         rd_valid_ff <= do_rd;
         cnt_ff      <= nxt_cnt;
         // reads wait for the start level, fixing latency
         primed_ff   <= (nxt_cnt == 4'h0) ? 1'b0 : (primed_ff || nxt_cnt >= start);
         err_ff      <= full || empty;
      end
   end

   // ***********************************
   // checks
   // ***********************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   property p_depth;
      cnt_ff <= lim;
   endproperty
   a_depth: assert property (p_depth) else $error("fifo holds more than its depth");

   property p_err;
      (full || empty) |=> err_ff;
   endproperty
   a_err: assert property (p_err) else $error("fifo error flag missed full or empty");

   property p_start;
      (!primed_ff && rd_tick) |=> !rd_valid_ff;
   endproperty
   a_start: assert property (p_start) else $error("fifo read before start level");

   c_full: cover property (full && wr_en);

endmodule

`default_nettype wire

// [rtl/rbo_top.sv]
/*
 * receive byte deserializer, byte ordering and phase compensation
 * fifo of one transceiver channel, with its register port.
 * assumes upstream symbols, lock, trigger and clock ticks are
 * all produced by logic on mclk.
 */
// Summary of operation
// - deserializer pairs two received symbols into one word at half rate.
// - deserializer is required above core limit, else may be bypassed.
// - single-width and double-width symbol modes are both supported.
// - search for ordering pattern, pad when it sits in upper lane.
// - alignment mode restarts the search on each rising lock edge.
// - first match in upper lane inserts exactly one pad symbol.
// - first match in lower lane inserts no pad.
// - after handling first match, order done status is raised.
// - user mode starts ordering on rising edge of trigger input.
// - data and status pass through a phase compensation fifo.
// - low-latency fifo is four deep, two to three cycles latency.
// - high-latency fifo is eight deep, four to five cycles latency.
// - write tick chosen by configuration from four clock sources.
// - deserializer enabled halves the chosen write tick.
// - read tick from core read clock if present, else per configuration.
// - fifo error output rises when fifo is full or empty.
`timescale 1ns/1ps
`default_nettype none
`include "rbo_params.svh"

module rbo_top (
   input  wire logic        mclk,
   input  wire logic        rstn,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata_ff,
   input  wire logic        in_valid,
   input  wire logic [15:0] in_data,
   input  wire logic        in_lock,
   input  wire logic        order_trig,
   input  wire logic        tick_tx,
   input  wire logic        tick_rec,
   input  wire logic        tick_central,
   input  wire logic        tick_master,
   input  wire logic        tick_core,
   output logic      [31:0] out_data_ff,
   output logic             out_done_ff,
   output logic             out_valid_ff,
   output logic             order_done_ff,
   output logic             fifo_err_ff
);

   // ***********************************
   // registers
   // ***********************************
   logic [31:0] ctrl_ff;
   logic [31:0] pat_ff;
   wire         sel_ctrl = (reg_addr == `RBO_ADDR_CTRL);
   wire         sel_pat  = (reg_addr == `RBO_ADDR_PATTERN);
   wire         sel_stat = (reg_addr == `RBO_ADDR_STATUS);
   wire         deser    = ctrl_ff[`RBO_CTRL_DESER_EN];
   wire         dw       = ctrl_ff[`RBO_CTRL_DWIDTH];
   wire         user_ord = ctrl_ff[`RBO_CTRL_USER_ORD];
   wire         ord_on   = ctrl_ff[`RBO_CTRL_ORD_EN] && deser;
   wire         hi_lat   = ctrl_ff[`RBO_CTRL_HI_LAT];
   wire         core_in  = ctrl_ff[`RBO_CTRL_CORE_INST];
   wire rbo_pkg::rbo_clk_cfg_type clk_cfg =
      rbo_pkg::rbo_clk_cfg_type'(ctrl_ff[`RBO_CTRL_CLKCFG_HI:`RBO_CTRL_CLKCFG_LO]);
   wire  [15:0] wmask    = dw ? 16'hffff : 16'h00ff;
   wire  [15:0] pat_sym  = pat_ff[`RBO_PAT_HI:`RBO_PAT_LO] & wmask;
   wire  [15:0] pad_sym  = pat_ff[`RBO_PAD_HI:`RBO_PAD_LO] & wmask;
   wire  [31:0] stat_word;
   wire  [31:0] rd_mux   = sel_ctrl ? ctrl_ff : sel_pat ? pat_ff : sel_stat ? stat_word : 32'h0000_0000;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ctrl_ff      <= `RBO_CTRL_RESET;
         pat_ff       <= `RBO_PATTERN_RESET;
         reg_rdata_ff <= 32'h0000_0000;
      end else begin
         if (reg_wr && sel_ctrl) begin
            ctrl_ff <= reg_wdata;
         end
         if (reg_wr && sel_pat) begin
            pat_ff <= reg_wdata;
         end
         reg_rdata_ff <= reg_rd ? rd_mux : 32'h0000_0000;
      end
   end

   // ***********************************
   // byte deserializer
   // ***********************************
   logic [15:0] lo_ff;
   logic        half_ff;
   wire  [15:0] sym     = in_data & wmask;
   wire         raw_vld = in_valid && (!deser || half_ff);
   wire  [15:0] raw_hi  = deser ? sym : 16'h0000;
   wire  [15:0] raw_lo  = deser ? lo_ff : sym;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         lo_ff   <= 16'h0000;
         half_ff <= 1'b0;
      end else if (in_valid && deser) begin
         lo_ff   <= sym;
         half_ff <= !half_ff;
      end else if (!deser) begin
         half_ff <= 1'b0;
      end
   end

   function automatic logic [31:0] pack(input logic dwm, input logic [15:0] h, input logic [15:0] l);
      pack = dwm ? {h, l} : {16'h0000, h[7:0], l[7:0]};
   endfunction

   // ***********************************
   // byte ordering
   // ***********************************
   rbo_pkg::rbo_ord_state_type ord_ff;
   logic        shift_ff;
   logic [15:0] held_ff;
   logic        lock_d_ff;
   logic        trig_d_ff;
   wire         srch     = (ord_ff == rbo_pkg::rbo_ord_search);
   wire         lock_up  = in_lock && !lock_d_ff;
   wire         trig_up  = order_trig && !trig_d_ff;
   wire         restart  = ord_on && (user_ord ? trig_up : lock_up);
   wire         match_lo = (raw_lo == pat_sym);
   wire         match_hi = (raw_hi == pat_sym);
   wire         hit_lo   = ord_on && srch && raw_vld && !restart && match_lo;
   wire         hit_hi   = ord_on && srch && raw_vld && !restart && !match_lo && match_hi;
   wire  [31:0] raw_word = pack(dw, raw_hi, raw_lo);
   wire  [31:0] ord_word = hit_lo ? raw_word :
                           hit_hi ? pack(dw, raw_lo, pad_sym) :
                           (ord_on && shift_ff) ? pack(dw, raw_lo, held_ff) : raw_word;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ord_ff        <= rbo_pkg::rbo_ord_idle;
         shift_ff      <= 1'b0;
         held_ff       <= 16'h0000;
         lock_d_ff     <= 1'b0;
         trig_d_ff     <= 1'b0;
         order_done_ff <= 1'b0;
      end else begin
         lock_d_ff <= in_lock;
         trig_d_ff <= order_trig;
         if (raw_vld) begin
            held_ff <= raw_hi;
         end
         if (hit_lo) begin
            shift_ff <= 1'b0;
         end else if (hit_hi) begin
            shift_ff <= 1'b1;
         end
         case (ord_ff)
            rbo_pkg::rbo_ord_idle: begin
               if (restart) begin
                  ord_ff        <= rbo_pkg::rbo_ord_search;
                  order_done_ff <= 1'b0;
               end
            end
            rbo_pkg::rbo_ord_search: begin
               if (restart) begin
                  order_done_ff <= 1'b0;
               end else if (hit_lo || hit_hi) begin
                  ord_ff        <= rbo_pkg::rbo_ord_idle;
                  order_done_ff <= 1'b1;
               end else if (!ord_on) begin
                  ord_ff <= rbo_pkg::rbo_ord_idle;
               end
            end
            default: begin
               ord_ff <= rbo_pkg::rbo_ord_idle;
            end
         endcase
      end
   end

   // ***********************************
   // clock selection for fifo ends
   // ***********************************
   logic        div_ff;
   wire         wsel = (clk_cfg == rbo_pkg::rbo_clk_nb_rm)   ? tick_tx :
                       (clk_cfg == rbo_pkg::rbo_clk_nb_norm) ? tick_rec :
                       (clk_cfg == rbo_pkg::rbo_clk_bond4)   ? tick_central : tick_master;
   wire         wr_tick = wsel && (!deser || div_ff);
   wire         rsel = (clk_cfg == rbo_pkg::rbo_clk_nb_rm)   ? tick_tx :
                       (clk_cfg == rbo_pkg::rbo_clk_nb_norm) ? tick_rec :
                       (clk_cfg == rbo_pkg::rbo_clk_bond4)   ? tick_central : tick_master;
   wire         rd_tick = core_in ? tick_core : rsel;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         div_ff <= 1'b0;
      end else if (wsel) begin
         div_ff <= !div_ff;
      end
   end

   // ***********************************
   // staging and fifo
   // ***********************************
   logic [31:0] stage_ff;
   logic        stage_vld_ff;
   wire         wr_en = stage_vld_ff && wr_tick;
   wire  [32:0] fifo_q;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         stage_ff     <= 32'h0000_0000;
         stage_vld_ff <= 1'b0;
      end else if (raw_vld) begin
         stage_ff     <= ord_word;
         stage_vld_ff <= 1'b1;
      end else if (wr_en) begin
         stage_vld_ff <= 1'b0;
      end
   end

   rbo_fifo #(
      .W (33)
   ) u_fifo (
      .mclk        (mclk),
      .rstn        (rstn),
      .hi_lat      (hi_lat),
      .wr_en       (wr_en),
      .wr_data     ({order_done_ff, stage_ff}),
      .rd_tick     (rd_tick),
      .rd_data_ff  (fifo_q),
      .rd_valid_ff (out_valid_ff),
      .err_ff      (fifo_err_ff)
   );

   assign out_data_ff = fifo_q[31:0];
   assign out_done_ff = fifo_q[32];
   assign stat_word   = {28'h0000_000, shift_ff, srch, fifo_err_ff, order_done_ff};

   // ***********************************
   // checks
   // ***********************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   property p_pair;
      (deser && in_valid && !half_ff) |=> (half_ff && !stage_vld_ff) || $past(stage_vld_ff);
   endproperty
   a_pair: assert property (p_pair) else $error("deserializer emitted on first symbol");

   property p_bypass;
      (!deser && in_valid) |=> stage_vld_ff && stage_ff == $past(raw_word);
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass word not staged");

   property p_width;
      (!dw && raw_vld) |=> stage_ff[31:16] == 16'h0000;
   endproperty
   a_width: assert property (p_width) else $error("single width word has upper bits");

   property p_pad;
      hit_hi |=> stage_ff == pack($past(dw), $past(raw_lo), $past(pad_sym)) && shift_ff && order_done_ff;
   endproperty
   a_pad: assert property (p_pad) else $error("pad not inserted for upper lane match");

   property p_nopad;
      hit_lo |=> stage_ff == $past(raw_word) && !shift_ff && order_done_ff;
   endproperty
   a_nopad: assert property (p_nopad) else $error("lower lane match altered data");

   property p_restart;
      (restart && ord_ff == rbo_pkg::rbo_ord_idle) |=> srch && !order_done_ff;
   endproperty
   a_restart: assert property (p_restart) else $error("trigger did not restart search");

   property p_shift;
      (ord_on && shift_ff && raw_vld && !srch) |=> stage_ff == pack($past(dw), $past(raw_lo), $past(held_ff));
   endproperty
   a_shift: assert property (p_shift) else $error("shifted lane lost after pad");

   property p_half;
      (deser && wr_tick) |=> !(deser && wr_tick);
   endproperty
   a_half: assert property (p_half) else $error("write tick not halved");

   c_pad: cover property (hit_hi);
   c_nopad: cover property (hit_lo);
   c_user: cover property (restart && user_ord);

endmodule

`default_nettype wire

// [tb/rbo_core_model.sv]
/*
 * user core logic model: makes the core read clock tick and keeps
 * every word handed out by the phase compensation fifo.
 * assumes the write tick of the block runs every second mclk cycle.
 */
`timescale 1ns/1ps
`default_nettype none

module rbo_core_model (
   input  wire logic        mclk,
   input  wire logic        rstn,
   input  wire logic        rd_en,
   input  wire logic [31:0] out_data_ff,
   input  wire logic        out_done_ff,
   input  wire logic        out_valid_ff,
   output logic             tick_core
);
   logic [32:0] got[$];

   // ***********************************
   // read tick, same rate as halved write tick
   // ***********************************
   always @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         tick_core <= 1'b0;
      end else begin
         tick_core <= rd_en & ~tick_core;
      end
   end

   // ***********************************
   // word capture
   // ***********************************
   always @(posedge mclk) begin
      if (rstn && out_valid_ff === 1'b1) begin
         got.push_back({out_done_ff, out_data_ff});
      end
   end
endmodule

`default_nettype wire

// [tb/rbo_top_tb_top.sv]
/*
 * self-checking bench of the receive byte ordering block.
 * assumes the design files and the core model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rbo_params.svh"

module rbo_top_tb_top;
   logic        mclk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, in_valid = 0;
   logic        in_lock = 0, order_trig = 0, core_rd = 0;
   logic [7:0]  reg_addr = 0;
   logic [31:0] reg_wdata = 0, reg_rdata_ff, out_data_ff, d;
   logic [15:0] in_data = 0;
   logic [3:0]  tick_on = 0;
   logic        tick_core, out_done_ff, out_valid_ff, order_done_ff, fifo_err_ff;
   int          fails = 0, checks = 0, cycles = 0;

   always #10 mclk = ~mclk;

   rbo_top u_dut (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .in_valid(in_valid),
      .in_data(in_data), .in_lock(in_lock), .order_trig(order_trig), .tick_tx(tick_on[0]),
      .tick_rec(tick_on[1]), .tick_central(tick_on[2]), .tick_master(tick_on[3]),
      .tick_core(tick_core), .out_data_ff(out_data_ff), .out_done_ff(out_done_ff),
      .out_valid_ff(out_valid_ff), .order_done_ff(order_done_ff), .fifo_err_ff(fifo_err_ff));

   rbo_core_model u_core (.mclk(mclk), .rstn(rstn), .rd_en(core_rd), .out_data_ff(out_data_ff),
      .out_done_ff(out_done_ff), .out_valid_ff(out_valid_ff), .tick_core(tick_core));

   // ***********************************
   // helpers
   // ***********************************
   task automatic complete_run;
      if (fails == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fails++;
         complete_run;
      end
   end

   task automatic chk(input string what, input logic [32:0] seen, input logic [32:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata_ff;
   endtask

   task automatic do_reset;
      @(posedge mclk);
      rstn <= 1'b0;
      in_valid <= 1'b0;
      in_lock <= 1'b0;
      order_trig <= 1'b0;
      repeat (5) @(posedge mclk);
      rstn <= 1'b1;
      u_core.got.delete();
   endtask

   // symbols never equal the pattern except at pat_at
   function automatic logic [15:0] sym(input int i, input logic dw, input int pat_at);
      if (i == pat_at) return dw ? 16'h55bc : 16'h00bc;
      return {dw ? 8'h01 : 8'h00, 1'b0, 7'(i)};
   endfunction

   function automatic logic [32:0] got_at(input int j);
      if (u_core.got.size() > j) return u_core.got[j];
      return 'x;
   endfunction

   // ***********************************
   // ordering run: k picks width, mode and lane
   // ***********************************
   task automatic order_run(input int k);
      logic        dw, usr, up, srch, sh;
      logic [15:0] pat, pad, u, l, prev;
      logic [31:0] w;
      logic [32:0] g;
      int          pat_at;
      dw = k[1];
      usr = k[0];
      up = ~(k[0] ^ k[1]);
      pat_at = up ? 41 : 40;
      pat = sym(pat_at, dw, pat_at);
      pad = dw ? 16'h77ee : 16'h00ee;
      do_reset;
      core_rd <= 1'b1;
      tick_on <= 4'b0001;
      wr_reg(`RBO_ADDR_PATTERN, {pad, pat});
      wr_reg(`RBO_ADDR_CTRL, 32'h89 | {30'h0, dw, 1'b0} | {29'h0, usr, 2'b0});
      u_core.got.delete();
      for (int i = 0; i < 64; i++) begin
         @(posedge mclk);
         in_valid <= 1'b1;
         in_data <= sym(i, dw, pat_at);
         if (i == 10) begin
            if (usr) order_trig <= 1'b1;
            else in_lock <= 1'b1;
         end
         if (i == 30) chk("done before match", order_done_ff, 0);
      end
      @(posedge mclk);
      in_valid <= 1'b0;
      repeat (20) @(posedge mclk);
      srch = 1;
      sh = 0;
      prev = 0;
      for (int j = 0; j < 26; j++) begin
         l = sym(2 * j, dw, pat_at);
         u = sym(2 * j + 1, dw, pat_at);
         if (srch && l == pat) begin
            w = {u, l};
            srch = 0;
            sh = 0;
         end else if (srch && u == pat) begin
            w = {l, pad};
            srch = 0;
            sh = 1;
         end else begin
            w = sh ? {l, prev} : {u, l};
         end
         prev = u;
         if (!dw) w = {16'h0, w[23:16], w[7:0]};
         g = got_at(j);
         chk("ordered word", {1'b0, g[31:0]}, {1'b0, w});
      end
      g = got_at(25);
      chk("done bit with data", {32'h0000_0000, g[32]}, 1);
      chk("order done", order_done_ff, 1);
      rd_reg(`RBO_ADDR_STATUS, d);
      chk("status", d & 32'hd, {29'h0, up, 3'b001});
      in_lock <= 1'b0;
      order_trig <= 1'b0;
      repeat (2) @(posedge mclk);
      if (usr) order_trig <= 1'b1;
      else in_lock <= 1'b1;
      repeat (3) @(posedge mclk);
      chk("done after retrigger", order_done_ff, 0);
   endtask

   // ***********************************
   // fifo run: c picks clock config and latency
   // ***********************************
   task automatic depth_run(input int c);
      int          dep;
      logic [15:0] lo, hi;
      dep = c[0] ? 8 : 4;
      do_reset;
      core_rd <= 1'b0;
      tick_on <= 4'b0001 << c;
      wr_reg(`RBO_ADDR_CTRL, 32'h89 | {27'h0, c[0], 4'h0} | {25'h0, 2'(c), 5'h0});
      u_core.got.delete();
      for (int i = 0; i < 40; i++) begin
         @(posedge mclk);
         in_valid <= 1'b1;
         in_data <= sym(i, 0, -1);
      end
      @(posedge mclk);
      in_valid <= 1'b0;
      repeat (4) @(posedge mclk);
      chk("fifo err full", fifo_err_ff, 1);
      core_rd <= 1'b1;
      repeat (60) @(posedge mclk);
      chk("words drained", u_core.got.size(), dep);
      lo = sym(2 * dep - 2, 0, -1);
      hi = sym(2 * dep - 1, 0, -1);
      chk("last held word", got_at(dep - 1), {17'h0, hi[7:0], lo[7:0]});
      chk("fifo err empty", fifo_err_ff, 1);
   endtask

   // ***********************************
   // bypass run: deserializer off, double width, read tick from tx tick
   // ***********************************
   task automatic bypass_run;
      logic [32:0] g;
      do_reset;
      core_rd <= 1'b0;
      tick_on <= 4'b0001;
      wr_reg(`RBO_ADDR_CTRL, 32'h0000_0002);
      u_core.got.delete();
      for (int i = 0; i < 12; i++) begin
         @(posedge mclk);
         in_valid <= 1'b1;
         in_data <= sym(i, 1, -1);
      end
      @(posedge mclk);
      in_valid <= 1'b0;
      repeat (10) @(posedge mclk);
      chk("bypass words", u_core.got.size(), 12);
      for (int j = 0; j < 12; j++) begin
         g = got_at(j);
         chk("bypass word", g, {17'h0_0000, sym(j, 1, -1)});
      end
   endtask

   // ***********************************
   // main sequence
   // ***********************************
   initial begin
      do_reset;
      rd_reg(`RBO_ADDR_CTRL, d);
      chk("ctrl reset", d, `RBO_CTRL_RESET);
      chk("fifo err after reset", fifo_err_ff, 1);
      rd_reg(`RBO_ADDR_PATTERN, d);
      chk("pattern reset", d, `RBO_PATTERN_RESET);
      wr_reg(`RBO_ADDR_PATTERN, 32'h77ee_55bc);
      rd_reg(`RBO_ADDR_PATTERN, d);
      chk("pattern write", d, 32'h77ee_55bc);
      wr_reg(8'h0c, 32'hffff_ffff);
      rd_reg(8'h0c, d);
      chk("unmapped read", d, 0);
      for (int k = 0; k < 4; k++) order_run(k);
      for (int c = 0; c < 4; c++) depth_run(c);
      bypass_run;
      complete_run;
   end
endmodule

`default_nettype wire
